// ===== error_pin_defines.svh
// Constants for the safety error pin output stage
`ifndef ERROR_PIN_DEFINES_SVH
`define ERROR_PIN_DEFINES_SVH

`define EP_ADDR_W        8
`define EP_CNT_W         16
`define EP_REACT_LIMIT   50

`define EP_OFS_CTRL      8'h00
`define EP_OFS_STATUS    8'h04
`define EP_OFS_MASK      8'h08
`define EP_OFS_PULSE_PRE 8'h0C
`define EP_OFS_HIGH_PRE  8'h10
`define EP_OFS_LOW_PRE   8'h14
`define EP_OFS_PIN_STATE 8'h18

`define EP_CTRL_BEAT     0
`define EP_ST_ERROR      0
`define EP_ST_RELEASE    1
`define EP_ST_W          2
`define EP_PIN_LEVEL     0
`define EP_PIN_FROZEN    1

`define EP_RST_PULSE_PRE 16'h0010
`define EP_RST_HIGH_PRE  16'h0008
`define EP_RST_LOW_PRE   16'h0008
`define EP_CNT_ONE       16'h0001

`define EP_RESP_OKAY     2'h0
`define EP_RESP_SLVERR   2'h2

`endif

// ===== error_pin_pkg.sv
// Types shared by the safety error pin output stage
package error_pin_pkg;

	typedef enum logic [1:0] {
		pin_idle,
		pin_pulse,
		pin_beat_high,
		pin_beat_low
	} pin_state_type;

endpackage : error_pin_pkg

// ===== pin_timer_if.sv
// Carrier between register file and pin timer
`timescale 1ns/100ps
`include "error_pin_defines.svh"

interface pin_timer_if;
	logic                 heartbeat_mode;
	logic                 error_active;
	logic [`EP_CNT_W-1:0] pulse_preload;
	logic [`EP_CNT_W-1:0] high_preload;
	logic [`EP_CNT_W-1:0] low_preload;
	logic                 pin_level;
	logic                 frozen;
	logic                 pulse_release;

	modport ctrl (
		output heartbeat_mode, error_active,
		output pulse_preload, high_preload, low_preload,
		input  pin_level, frozen, pulse_release
	);
	modport timer (
		input  heartbeat_mode, error_active,
		input  pulse_preload, high_preload, low_preload,
		output pin_level, frozen, pulse_release
	);
endinterface : pin_timer_if

// ===== pin_timer.sv
// Pulse and heartbeat sequencer for the error pin
`timescale 1ns/100ps
`include "error_pin_defines.svh"

module pin_timer (
	// Clock and reset
	input  wire logic  aclk,
	input  wire logic  aresetn,
	// Control and status
	pin_timer_if.timer tmr
);

	error_pin_pkg::pin_state_type state;
	error_pin_pkg::pin_state_type next_state;
	logic [`EP_CNT_W-1:0]         cnt;
	logic [`EP_CNT_W-1:0]         next_cnt;
	logic                         pin;
	logic                         next_pin;
	logic                         release_now;

	always_comb begin
		next_state  = state;
		next_cnt    = cnt;
		release_now = 1'b0;
		unique case (state)
			error_pin_pkg::pin_idle: begin
				if (tmr.heartbeat_mode) begin
					next_state = error_pin_pkg::pin_beat_high;
					next_cnt   = `EP_CNT_ONE;
				end else if (tmr.error_active) begin
					next_state = error_pin_pkg::pin_pulse;
					next_cnt   = `EP_CNT_ONE;
				end
			end
			error_pin_pkg::pin_pulse: begin
				// Pulse is not cut short by a mode change, only by reset or a lower pulse preload
				if (cnt >= tmr.pulse_preload) begin
					if (!tmr.error_active) begin
						next_state  = error_pin_pkg::pin_idle;
						release_now = 1'b1;
					end
				end else begin
					next_cnt = cnt + `EP_CNT_ONE;
				end
			end
			error_pin_pkg::pin_beat_high: begin
				if (!tmr.heartbeat_mode) begin
					next_state = error_pin_pkg::pin_idle;
				end else if (!tmr.error_active) begin
					if (cnt >= tmr.high_preload) begin
						next_state = error_pin_pkg::pin_beat_low;
						next_cnt   = `EP_CNT_ONE;
					end else begin
						next_cnt = cnt + `EP_CNT_ONE;
					end
				end
			end
			error_pin_pkg::pin_beat_low: begin
				if (!tmr.heartbeat_mode) begin
					next_state = error_pin_pkg::pin_idle;
				end else if (!tmr.error_active) begin
					if (cnt >= tmr.low_preload) begin
						next_state = error_pin_pkg::pin_beat_high;
						next_cnt   = `EP_CNT_ONE;
					end else begin
						next_cnt = cnt + `EP_CNT_ONE;
					end
				end
			end
		endcase
	end

	assign next_pin = (next_state != error_pin_pkg::pin_pulse) &&
	                  (next_state != error_pin_pkg::pin_beat_low);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= error_pin_pkg::pin_idle;
			cnt   <= '0;
			pin   <= 1'b1;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			pin   <= next_pin;
		end
	end

	assign tmr.pin_level     = pin;
	assign tmr.pulse_release = release_now;
	assign tmr.frozen        = tmr.error_active &&
	                           ((state == error_pin_pkg::pin_beat_high) ||
	                            (state == error_pin_pkg::pin_beat_low));

endmodule : pin_timer

// ===== error_pin_output.sv
// Error pin output stage with AXI4-Lite registers and interrupt
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "error_pin_defines.svh"

module error_pin_output (
	// Clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// AXI4-Lite write address
	input  wire logic [`EP_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]            s_axi_awprot,
	input  wire logic                  s_axi_awvalid,
	output wire logic                  s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output wire logic                  s_axi_wready,
	// AXI4-Lite write response
	output var  logic [1:0]            s_axi_bresp,
	output var  logic                  s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [`EP_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]            s_axi_arprot,
	input  wire logic                  s_axi_arvalid,
	output wire logic                  s_axi_arready,
	// AXI4-Lite read data
	output var  logic [31:0]           s_axi_rdata,
	output var  logic [1:0]            s_axi_rresp,
	output var  logic                  s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// Error source, same clock domain
	input  wire logic                  error_event,
	// Pin and interrupt
	output wire logic                  safety_error_pin_n,
	output wire logic                  irq
);

	pin_timer_if tif ();

	logic                  beat_enable;
	logic [`EP_ST_W-1:0]   status;
	logic [`EP_ST_W-1:0]   next_status;
	logic [`EP_ST_W-1:0]   mask;
	logic [`EP_CNT_W-1:0]  pulse_pre;
	logic [`EP_CNT_W-1:0]  high_pre;
	logic [`EP_CNT_W-1:0]  low_pre;

	wire                   wr_fire;
	wire                   rd_fire;
	wire                   wr_ctrl;
	wire                   wr_status;
	wire                   wr_mask;
	wire                   wr_pulse;
	wire                   wr_high;
	wire                   wr_low;
	wire                   wr_known;
	wire [`EP_ST_W-1:0]    clear_bits;
	wire [`EP_ST_W-1:0]    set_bits;
	wire [31:0]            wmask;
	wire [`EP_CNT_W-1:0]   pre_data;
	wire [`EP_CNT_W-1:0]   pre_mask;
	wire [31:0]            rd_word;
	wire                   rd_known;

	// Write address and data are taken together, one at a time
	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_wready  = s_axi_awready;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire       = s_axi_awready;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;

	assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
	                {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
	// Preloads honour the strobes of their two low byte lanes
	assign pre_data = s_axi_wdata[`EP_CNT_W-1:0];
	assign pre_mask = wmask[`EP_CNT_W-1:0];

	assign wr_ctrl   = wr_fire && (s_axi_awaddr == `EP_OFS_CTRL);
	assign wr_status = wr_fire && (s_axi_awaddr == `EP_OFS_STATUS);
	assign wr_mask   = wr_fire && (s_axi_awaddr == `EP_OFS_MASK);
	assign wr_pulse  = wr_fire && (s_axi_awaddr == `EP_OFS_PULSE_PRE);
	assign wr_high   = wr_fire && (s_axi_awaddr == `EP_OFS_HIGH_PRE);
	assign wr_low    = wr_fire && (s_axi_awaddr == `EP_OFS_LOW_PRE);
	assign wr_known  = wr_ctrl || wr_status || wr_mask || wr_pulse ||
	                   wr_high || wr_low ||
	                   (s_axi_awaddr == `EP_OFS_PIN_STATE);

	// Set wins over a write-one clear in the same cycle
	assign clear_bits = wr_status ?
	                    (s_axi_wdata[`EP_ST_W-1:0] & wmask[`EP_ST_W-1:0]) :
	                    '0;
	assign set_bits   = {tif.pulse_release, error_event};
	assign next_status = (status & ~clear_bits) | set_bits;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status <= '0;
		end else begin
			status <= next_status;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			beat_enable <= 1'b0;
			mask        <= '0;
			pulse_pre   <= `EP_RST_PULSE_PRE;
			high_pre    <= `EP_RST_HIGH_PRE;
			low_pre     <= `EP_RST_LOW_PRE;
		end else begin
			if (wr_ctrl && s_axi_wstrb[0])
				beat_enable <= s_axi_wdata[`EP_CTRL_BEAT];
			if (wr_mask && s_axi_wstrb[0])
				mask <= s_axi_wdata[`EP_ST_W-1:0];
			if (wr_pulse)
				pulse_pre <= (pre_data & pre_mask) | (pulse_pre & ~pre_mask);
			if (wr_high)
				high_pre <= (pre_data & pre_mask) | (high_pre & ~pre_mask);
			if (wr_low)
				low_pre <= (pre_data & pre_mask) | (low_pre & ~pre_mask);
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `EP_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_known ? `EP_RESP_OKAY : `EP_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read mux
	assign rd_known = (s_axi_araddr == `EP_OFS_CTRL) ||
	                  (s_axi_araddr == `EP_OFS_STATUS) ||
	                  (s_axi_araddr == `EP_OFS_MASK) ||
	                  (s_axi_araddr == `EP_OFS_PULSE_PRE) ||
	                  (s_axi_araddr == `EP_OFS_HIGH_PRE) ||
	                  (s_axi_araddr == `EP_OFS_LOW_PRE) ||
	                  (s_axi_araddr == `EP_OFS_PIN_STATE);
	assign rd_word =
		(s_axi_araddr == `EP_OFS_CTRL)      ? {31'h0, beat_enable} :
		(s_axi_araddr == `EP_OFS_STATUS)    ? {30'h0, status} :
		(s_axi_araddr == `EP_OFS_MASK)      ? {30'h0, mask} :
		(s_axi_araddr == `EP_OFS_PULSE_PRE) ? {16'h0, pulse_pre} :
		(s_axi_araddr == `EP_OFS_HIGH_PRE)  ? {16'h0, high_pre} :
		(s_axi_araddr == `EP_OFS_LOW_PRE)   ? {16'h0, low_pre} :
		(s_axi_araddr == `EP_OFS_PIN_STATE) ?
			{30'h0, tif.frozen, tif.pin_level} : 32'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= `EP_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_known ? `EP_RESP_OKAY : `EP_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Error stays active until software clears the sticky bit
	assign tif.heartbeat_mode = beat_enable;
	assign tif.error_active   = status[`EP_ST_ERROR];
	assign tif.pulse_preload  = pulse_pre;
	assign tif.high_preload   = high_pre;
	assign tif.low_preload    = low_pre;

	pin_timer u_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tmr     (tif.timer)
	);

	assign safety_error_pin_n = tif.pin_level;
	assign irq                = |(status & mask);

endmodule : error_pin_output

// ===== safety_watcher.sv
// External safety monitor model measuring error pin phase lengths
`timescale 1ns/100ps
module safety_watcher (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Observed pin
	input  wire logic        pin_n,
	// Measured phases in clock cycles
	output logic      [15:0] run_len,
	output logic      [15:0] last_low,
	output logic      [15:0] last_high
);
	logic prev;
	always_ff @(posedge aclk) begin
		prev <= pin_n;
		if (!aresetn) begin
			run_len <= 16'h0000;
			last_low <= 16'h0000;
			last_high <= 16'h0000;
		end else if (pin_n != prev) begin
			run_len <= 16'h0001;
			// Length of the phase that just ended
			if (prev) last_high <= run_len;
			else last_low <= run_len;
		end else
			run_len <= run_len + 16'h0001;
	end
endmodule : safety_watcher

// ===== error_pin_monitor.sv
// Concurrent checks on the error pin output stage ports
`timescale 1ns/100ps
module error_pin_monitor (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshake
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Error source and outputs
	input wire logic error_event,
	input wire logic safety_error_pin_n,
	input wire logic irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid
		&& !s_axi_bvalid |=> s_axi_bvalid) else $error("write unanswered");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid) else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid
		|=> s_axi_rvalid) else $error("read unanswered");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid) else $error("read response dropped");
	a_reset_quiet: assert property (disable iff (1'b0) !aresetn
		|=> safety_error_pin_n && !irq) else $error("pin not idle");
	a_pin_settles: assert property (error_event && !s_axi_awvalid
		##1 !s_axi_awvalid [*6] |-> $stable(safety_error_pin_n))
		else $error("pin moved after error");
endmodule : error_pin_monitor
bind error_pin_output error_pin_monitor u_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.error_event(error_event), .safety_error_pin_n(safety_error_pin_n),
	.irq(irq)
);

// ===== testbench.sv
// Self-checking bench for the error pin output stage
`timescale 1ns/100ps
`include "error_pin_defines.svh"
module testbench;
	logic aclk, aresetn, awv, wv, brdy, arv, rrdy, err_ev;
	logic [7:0] awa, ara;
	logic [31:0] wd;
	wire awr, wr_r, bv, arr, rv, pin, irq;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	wire [15:0] run_len, last_low, last_high;
	int err_count, total_checks, n;
	logic p;
	error_pin_output dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rrdy), .error_event(err_ev),
		.safety_error_pin_n(pin), .irq(irq));
	safety_watcher u_watch (.aclk(aclk), .aresetn(aresetn), .pin_n(pin),
		.run_len(run_len), .last_low(last_low), .last_high(last_high));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : stop_test
	task automatic tick(inout int c);
		@(posedge aclk);
		c++;
		if (c > 400) begin
			err_count++;
			stop_test();
		end
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] r);
		int c;
		bit aw_done;
		bit w_done;
		c = 0;
		aw_done = 1'b0;
		w_done = 1'b0;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		// Each channel is released at its own handshake
		while (!aw_done || !w_done) begin
			tick(c);
			if (!aw_done && awr === 1'b1) begin
				aw_done = 1'b1;
				awv <= 1'b0;
			end
			if (!w_done && wr_r === 1'b1) begin
				w_done = 1'b1;
				wv <= 1'b0;
			end
		end
		do tick(c); while (bv !== 1'b1);
		brdy <= 1'b0;
		cmp({30'h0, br}, {30'h0, r});
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] r);
		int c;
		c = 0;
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		do tick(c); while (arr !== 1'b1);
		arv <= 1'b0;
		do tick(c); while (rv !== 1'b1);
		rrdy <= 1'b0;
		cmp(rdat, d);
		cmp({30'h0, rr}, {30'h0, r});
		@(posedge aclk);
	endtask : rd
	task automatic wait_pin(input logic v);
		n = 0;
		while (pin !== v) tick(n);
	endtask : wait_pin
	task automatic fire;
		err_ev <= 1'b1;
		@(posedge aclk);
		err_ev <= 1'b0;
	endtask : fire
	task automatic test_regs;
		rd(`EP_OFS_CTRL, 32'h0, `EP_RESP_OKAY);
		rd(`EP_OFS_STATUS, 32'h0, `EP_RESP_OKAY);
		rd(`EP_OFS_MASK, 32'h0, `EP_RESP_OKAY);
		rd(`EP_OFS_PULSE_PRE, {16'h0, `EP_RST_PULSE_PRE}, `EP_RESP_OKAY);
		rd(`EP_OFS_HIGH_PRE, {16'h0, `EP_RST_HIGH_PRE}, `EP_RESP_OKAY);
		rd(`EP_OFS_LOW_PRE, {16'h0, `EP_RST_LOW_PRE}, `EP_RESP_OKAY);
		rd(`EP_OFS_PIN_STATE, 32'h1, `EP_RESP_OKAY);
		rd(8'h1C, 32'h0, `EP_RESP_SLVERR);
		wr(8'h1C, 32'h5, `EP_RESP_SLVERR);
		$display("test_regs done");
	endtask : test_regs
	task automatic test_pulse;
		wr(`EP_OFS_PULSE_PRE, 32'h14, `EP_RESP_OKAY);
		wr(`EP_OFS_MASK, 32'h1, `EP_RESP_OKAY);
		fire();
		wait_pin(1'b0);
		cmp({31'h0, n <= `EP_REACT_LIMIT}, 32'h1);
		cmp({31'h0, irq}, 32'h1);
		// Clear early so the minimum width is what holds the pin
		wr(`EP_OFS_STATUS, 32'h1, `EP_RESP_OKAY);
		wait_pin(1'b1);
		@(posedge aclk);
		cmp({31'h0, last_low >= 16'h0014}, 32'h1);
		cmp({31'h0, irq}, 32'h0);
		rd(`EP_OFS_STATUS, 32'h2, `EP_RESP_OKAY);
		wr(`EP_OFS_STATUS, 32'h2, `EP_RESP_OKAY);
		$display("test_pulse done");
	endtask : test_pulse
	task automatic test_beat;
		wr(`EP_OFS_HIGH_PRE, 32'h3, `EP_RESP_OKAY);
		wr(`EP_OFS_LOW_PRE, 32'h5, `EP_RESP_OKAY);
		wr(`EP_OFS_CTRL, 32'h1, `EP_RESP_OKAY);
		wait_pin(1'b0);
		wait_pin(1'b1);
		wait_pin(1'b0);
		@(posedge aclk);
		cmp({16'h0, last_high}, 32'h3);
		cmp({16'h0, last_low}, 32'h5);
		fire();
		repeat (4) @(posedge aclk);
		p = pin;
		repeat (20) @(posedge aclk);
		cmp({31'h0, pin}, {31'h0, p});
		rd(`EP_OFS_PIN_STATE, {30'h0, 1'b1, p}, `EP_RESP_OKAY);
		wr(`EP_OFS_STATUS, 32'h1, `EP_RESP_OKAY);
		wait_pin(!p);
		cmp({31'h0, n <= 10}, 32'h1);
		wr(`EP_OFS_CTRL, 32'h0, `EP_RESP_OKAY);
		wait_pin(1'b1);
		$display("test_beat done");
	endtask : test_beat
	task automatic test_reset;
		// Only the release event unmasked: the error must not interrupt
		wr(`EP_OFS_MASK, 32'h2, `EP_RESP_OKAY);
		fire();
		wait_pin(1'b0);
		cmp({31'h0, n <= `EP_REACT_LIMIT}, 32'h1);
		cmp({31'h0, irq}, 32'h0);
		// Reset in mid-pulse cuts the pulse and restores every register
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		cmp({31'h0, pin}, 32'h1);
		cmp({31'h0, irq}, 32'h0);
		rd(`EP_OFS_STATUS, 32'h0, `EP_RESP_OKAY);
		rd(`EP_OFS_MASK, 32'h0, `EP_RESP_OKAY);
		rd(`EP_OFS_PULSE_PRE, {16'h0, `EP_RST_PULSE_PRE}, `EP_RESP_OKAY);
		rd(`EP_OFS_PIN_STATE, 32'h1, `EP_RESP_OKAY);
		$display("test_reset done");
	endtask : test_reset
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	initial begin
		{aresetn, awv, wv, brdy, arv, rrdy, err_ev} = 7'h00;
		awa = 8'h00;
		ara = 8'h00;
		wd = 32'h0;
		err_count = 0;
		total_checks = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		test_regs();
		test_pulse();
		test_beat();
		test_reset();
		stop_test();
	end
endmodule : testbench
